// File: inc/wdcf_defines.svh
// Register offsets, field positions, reset values and timing counts of the watchdog flags block.
`ifndef WDCF_DEFINES_SVH
`define WDCF_DEFINES_SVH
`define WDCF_OFS_CTRL        4'h0
`define WDCF_OFS_SELECT      4'h1
`define WDCF_OFS_IRQ_EN      4'h2
`define WDCF_OFS_CAUSE       4'h3
`define WDCF_OFS_EV_STATUS   4'h4
`define WDCF_OFS_EV_CLEAR    4'h5
`define WDCF_OFS_EV_ENABLE   4'h6
`define WDCF_OFS_COUNT       4'h7
`define WDCF_BIT_RESTART     0
`define WDCF_BIT_RST_EN      1
`define WDCF_BIT_RST_FLAG    2
`define WDCF_BIT_IRQ_FLAG    3
`define WDCF_BIT_IRQ_EN      4
`define WDCF_BIT_UNLOCK      0
`define WDCF_SEL_RESET       3'h7
`define WDCF_RST_EN_RESET    1'b1
`define WDCF_CNT_W           30
`define WDCF_DIV_W           4
`define WDCF_RESET_PULSE     8'h10
`endif

// File: inc/wdcf_pkg.sv
// Types shared by the watchdog flags block.
package wdcf_pkg;
  typedef enum logic [1:0] {
    WDCF_RUN   = 2'b00,
    WDCF_HALT  = 2'b01,
    WDCF_SLOW  = 2'b10
  } wdcf_mode_t;

  typedef struct packed {
    logic [29:0] count;
    logic [3:0]  slowDiv;
    logic [2:0]  timeoutSelect;
    logic        expiryResetEnable;
    logic        timeoutIrqFlag;
    logic        dogResetCauseFlag;
    logic        expiryIrqEnable;
    logic        unlocked;
    logic [1:0]  evStatus;
    logic [1:0]  evEnable;
    logic [7:0]  resetPulse;
    logic        waitReq;
    logic        readValid;
    logic [31:0] readData;
    logic        irq;
    logic        sysReset;
  } wdcf_state_t;
endpackage : wdcf_pkg

// File: src/wdcf_watchdog_flags.sv
// Watchdog counter with control and status flags on an Avalon-MM slave.
//
// Overview of operation
// - Expiry of every period sets the timeout flag regardless of interrupt enable.
// - A separate interrupt enable gates only the request, never the flag.
// - Any hardware reset clears the watchdog reset cause flag.
// - After a watchdog-caused reset the cause flag reads one.
// - Software may clear the cause flag by writing it.
// - Reset enable set makes expiry reset the system; else only flag.
// - Out of reset, watchdog reset enabled and timeout select longest.
// - Writing one to the restart strobe returns the counter to zero only after an unlock write to the cause register.
// - Restart strobe has no storage and always reads back zero.
// - 30-bit counter on CPU clock; halted in idle/stop, slowed in slow mode.
// - Timeout select codes 0..7 pick the expiry count; reset code 7.
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "wdcf_defines.svh"

module wdcf_watchdog_flags (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        dogResetSeen,
  input  wire logic [1:0]  powerMode,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             timeoutIrq,
  output logic             eventIrq,
  output logic             systemReset
);

  wdcf_pkg::wdcf_state_t q;
  wdcf_pkg::wdcf_state_t d;

  logic        access;
  logic        wrTake;
  logic        tick;
  logic        expire;
  logic [30:0] limit;
  logic [7:0]  wb;

  // One wait cycle per access: the answer lands on the second edge of the request.
  assign access = (avs_read | avs_write) & q.waitReq;
  assign wrTake = avs_write & q.waitReq & avs_byteenable[0];
  assign wb     = avs_writedata[7:0];

  always_comb begin
    case (q.timeoutSelect)
      3'h0:    limit = 31'h00020000;
      3'h1:    limit = 31'h00100000;
      3'h2:    limit = 31'h00800000;
      3'h3:    limit = 31'h04000000;
      3'h4:    limit = 31'h08000000;
      3'h5:    limit = 31'h10000000;
      3'h6:    limit = 31'h20000000;
      default: limit = 31'h40000000;
    endcase
  end

  always_comb begin
    case (wdcf_pkg::wdcf_mode_t'(powerMode))
      wdcf_pkg::WDCF_RUN:  tick = 1'b1;
      wdcf_pkg::WDCF_SLOW: tick = (q.slowDiv == 4'hf);
      default:             tick = 1'b0;
    endcase
  end

  assign expire = tick && ({1'b0, q.count} == (limit - 31'h1));

  always_comb begin
    d = q;
    d.readValid = 1'b0;
    d.waitReq   = 1'b1;
    if (access) begin
      d.waitReq = 1'b0;
    end
    if (powerMode == 2'b10) begin
      d.slowDiv = q.slowDiv + 4'h1;
    end

    if (tick) begin
      d.count = q.count + 30'h1;
    end
    if (expire) begin
      d.count = '0;
    end

    if (wrTake) begin
      if (avs_address == `WDCF_OFS_CTRL) begin
        d.expiryResetEnable = wb[`WDCF_BIT_RST_EN];
        if (!wb[`WDCF_BIT_IRQ_FLAG]) begin
          d.timeoutIrqFlag = 1'b0;
        end
        if (!wb[`WDCF_BIT_RST_FLAG]) begin
          d.dogResetCauseFlag = 1'b0;
        end
        if (wb[`WDCF_BIT_RESTART] && q.unlocked) begin
          d.count = '0;
        end
        d.unlocked = 1'b0;
      end else if (avs_address == `WDCF_OFS_SELECT) begin
        d.timeoutSelect = wb[2:0];
      end else if (avs_address == `WDCF_OFS_IRQ_EN) begin
        d.expiryIrqEnable = wb[`WDCF_BIT_IRQ_EN];
      end else if (avs_address == `WDCF_OFS_CAUSE) begin
        d.unlocked = wb[`WDCF_BIT_UNLOCK];
      end else if (avs_address == `WDCF_OFS_EV_CLEAR) begin
        d.evStatus = q.evStatus & ~wb[1:0];
      end else if (avs_address == `WDCF_OFS_EV_ENABLE) begin
        d.evEnable = wb[1:0];
      end
    end

    if (expire) begin
      d.timeoutIrqFlag = 1'b1;
      d.evStatus[0]    = 1'b1;
      if (q.expiryResetEnable) begin
        d.resetPulse = `WDCF_RESET_PULSE;
        d.evStatus[1] = 1'b1;
      end
    end
    if (q.resetPulse != 8'h00) begin
      d.resetPulse = q.resetPulse - 8'h01;
    end

    if (avs_read && q.waitReq) begin
      d.readValid = 1'b1;
      d.readData  = '0;
      if (avs_address == `WDCF_OFS_CTRL) begin
        d.readData[`WDCF_BIT_RST_EN]   = q.expiryResetEnable;
        d.readData[`WDCF_BIT_RST_FLAG] = q.dogResetCauseFlag;
        d.readData[`WDCF_BIT_IRQ_FLAG] = q.timeoutIrqFlag;
      end else if (avs_address == `WDCF_OFS_SELECT) begin
        d.readData[2:0] = q.timeoutSelect;
      end else if (avs_address == `WDCF_OFS_IRQ_EN) begin
        d.readData[`WDCF_BIT_IRQ_EN] = q.expiryIrqEnable;
      end else if (avs_address == `WDCF_OFS_CAUSE) begin
        d.readData[`WDCF_BIT_UNLOCK] = q.unlocked;
      end else if (avs_address == `WDCF_OFS_EV_STATUS) begin
        d.readData[1:0] = q.evStatus;
      end else if (avs_address == `WDCF_OFS_EV_ENABLE) begin
        d.readData[1:0] = q.evEnable;
      end else if (avs_address == `WDCF_OFS_COUNT) begin
        d.readData[29:0] = q.count;
      end
    end

    d.irq      = d.timeoutIrqFlag & d.expiryIrqEnable;
    d.sysReset = (d.resetPulse != 8'h00);
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      q                   <= '0;
      q.waitReq           <= 1'b1;
      q.timeoutSelect     <= `WDCF_SEL_RESET;
      q.expiryResetEnable <= `WDCF_RST_EN_RESET;
      // cleared by reset; set again below.
      q.dogResetCauseFlag <= 1'b0;
    end else begin
      q <= d;
      if (dogResetSeen) begin
        q.dogResetCauseFlag <= 1'b1;
      end
    end
  end

  assign avs_readdata    = q.readData;
  assign avs_waitrequest = q.waitReq;
  assign timeoutIrq      = q.irq;
  assign systemReset     = q.sysReset;

  // Level interrupt for the event status bits; software clears via the clear register.
  logic evIrq_q;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      evIrq_q <= 1'b0;
    end else begin
      evIrq_q <= |(d.evStatus & d.evEnable);
    end
  end
  assign eventIrq = evIrq_q;

endmodule : wdcf_watchdog_flags

// File: testbench/wdcf_watchdog_flags_sva.sv
// Port-level assertions for the watchdog flags block.
`timescale 1ns/100ps
module wdcf_watchdog_flags_sva (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        timeoutIrq,
  input wire logic        eventIrq,
  input wire logic        systemReset
);
  wire logic rdDone = avs_read && !avs_waitrequest;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_restart_zero: assert property (rdDone && avs_address == 4'h0 |->
    avs_readdata[0] == 1'b0 && avs_readdata[31:5] == 27'h0) else $error("strobe bit read back");
  chk_select_bits: assert property (rdDone && avs_address == 4'h1 |->
    avs_readdata[31:3] == 29'h0) else $error("select wider than three bits");
  chk_count_width: assert property (rdDone && avs_address == 4'h7 |->
    avs_readdata[31:30] == 2'h0) else $error("counter wider than 30 bits");
  // A flag that drops with no software write means it was cleared on its own.
  chk_irq_sticky: assert property ($fell(timeoutIrq) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("timeout interrupt dropped without a write");
  chk_reset_quiet: assert property ($rose(rst_b) |-> avs_waitrequest && !timeoutIrq &&
    !eventIrq && !systemReset) else $error("outputs active out of reset");
  chk_sysrst_hold: assert property ($rose(systemReset) |-> systemReset [*8])
    else $error("system reset pulse too short");
endmodule : wdcf_watchdog_flags_sva
bind wdcf_watchdog_flags wdcf_watchdog_flags_sva wdcf_watchdog_flags_sva_inst (.clock, .rst_b,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .timeoutIrq,
  .eventIrq, .systemReset);

// File: testbench/wdcf_watchdog_flags_tb_top.sv
// Self-checking bench for the watchdog flags block.
`timescale 1ns/100ps
module wdcf_watchdog_flags_tb_top;
  logic        clock, rst_b, dogResetSeen, avs_read, avs_write;
  logic        avs_waitrequest, timeoutIrq, eventIrq, systemReset;
  logic [1:0]  powerMode;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rv, c0;
  logic [31:0] seed = 32'h9ee093a3;
  int          bad_count = 0, total_checks = 0, cyc = 0, n;
  wdcf_watchdog_flags wdcf_watchdog_flags_inst (.*);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // One expiry at the shortest timeout dominates the run length.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 200000) begin
      bad_count++;
      give_verdict();
    end
  end
  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lf
  function automatic logic [31:0] sel(input logic [31:0] d);
    return {29'h0, d[2:0]};
  endfunction : sel
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // No latency is assumed: the request stands until waitrequest is seen low.
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rv, e);
  endtask : rdc
  task automatic doReset(input logic s);
    @(posedge clock);
    rst_b <= 1'b0;
    dogResetSeen <= s;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    dogResetSeen <= 1'b0;
  endtask : doReset
  initial begin
    {rst_b, dogResetSeen, avs_read, avs_write, avs_address, avs_writedata} = '0;
    powerMode = 2'h0;
    avs_byteenable = 4'hf;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rdc(4'h0, 32'h2);
    rdc(4'h1, 32'h7);
    rdc(4'hf, 32'h0);
    for (int i = 0; i < 8; i++) begin
      seed = lf(seed);
      acc(1'b1, 4'h1, {seed[31:3], 3'(i)});
      rdc(4'h1, sel({seed[31:3], 3'(i)}));
    end
    acc(1'b0, 4'h7, 32'h0);
    c0 = rv;
    acc(1'b1, 4'h0, 32'hf);
    acc(1'b0, 4'h7, 32'h0);
    chk(32'(rv > c0), 32'h1);
    acc(1'b1, 4'h3, 32'h1);
    acc(1'b1, 4'h0, 32'hf);
    acc(1'b0, 4'h7, 32'h0);
    chk(32'(rv < 8), 32'h1);
    powerMode <= 2'h1;
    acc(1'b0, 4'h7, 32'h0);
    c0 = rv;
    repeat (10) @(posedge clock);
    rdc(4'h7, c0);
    powerMode <= 2'h3;
    repeat (10) @(posedge clock);
    rdc(4'h7, c0);
    powerMode <= 2'h2;
    acc(1'b0, 4'h7, 32'h0);
    c0 = rv;
    repeat (160) @(posedge clock);
    acc(1'b0, 4'h7, 32'h0);
    chk(32'((rv - c0) inside {[10:11]}), 32'h1);
    powerMode <= 2'h0;
    acc(1'b1, 4'h1, 32'h0);
    acc(1'b1, 4'h2, 32'h10);
    acc(1'b1, 4'h6, 32'h1);
    acc(1'b1, 4'h3, 32'h1);
    acc(1'b1, 4'h0, 32'h3);
    for (n = 0; timeoutIrq !== 1'b1 && n < 140000; n++) @(posedge clock);
    chk(32'(timeoutIrq), 32'h1);
    for (n = 0; systemReset !== 1'b1 && n < 64; n++) @(posedge clock);
    chk(32'(systemReset), 32'h1);
    acc(1'b0, 4'h7, 32'h0);
    chk(32'(rv < 16), 32'h1);
    acc(1'b0, 4'h0, 32'h0);
    chk(rv & 32'h8, 32'h8);
    chk(32'(eventIrq), 32'h1);
    acc(1'b1, 4'h5, 32'h1);
    repeat (2) @(posedge clock);
    chk(32'(eventIrq), 32'h0);
    acc(1'b1, 4'h0, 32'h6);
    repeat (2) @(posedge clock);
    chk(32'(timeoutIrq), 32'h0);
    doReset(1'b1);
    rdc(4'h0, 32'h6);
    acc(1'b1, 4'h0, 32'h2);
    rdc(4'h0, 32'h2);
    doReset(1'b1);
    doReset(1'b0);
    rdc(4'h0, 32'h2);
    give_verdict();
  end
endmodule : wdcf_watchdog_flags_tb_top
